// ---- hdl/touch_cmd_pkg.sv ----
package touch_cmd_pkg;

	// fixed upper six bits of the bus address
	localparam logic [5:0] ADDR_FIXED     = 6'h24;
	// positions inside the received address byte
	localparam int         ADDR_SEL_BIT   = 1;
	localparam int         ADDR_RW_BIT    = 0;

	// field positions of the command byte
	localparam int         CMD_START_BIT  = 7;
	localparam int         CMD_CHAN_HI    = 6;
	localparam int         CMD_CHAN_LO    = 4;
	localparam int         CMD_PD_BIT     = 2;
	localparam int         CMD_MODE_BIT   = 1;

	// values after reset of the command fields and mode state
	localparam logic       START_RST      = 1'h1;
	localparam logic [2:0] CHAN_RST       = 3'h4;
	localparam logic       PD_RST         = 1'h0;
	localparam logic       MODE_RST       = 1'h0;
	localparam logic       ASLEEP_RST     = 1'h0;

	// rising scl counts since start, numbered as on the wire
	localparam logic [5:0] CNT_SAMPLE_FALL = 6'h07;
	localparam logic [5:0] CNT_ADDR_LAST   = 6'h08;
	localparam logic [5:0] CNT_ADDR_ACK    = 6'h09;
	localparam logic [5:0] CNT_CMD_APPLY   = 6'h10;
	localparam logic [5:0] CNT_CMD_LAST    = 6'h11;
	localparam logic [5:0] CNT_CMD_ACK     = 6'h12;
	localparam logic [5:0] CNT_BYTE1_LAST  = 6'h11;
	localparam logic [5:0] CNT_BYTE1_ACK   = 6'h12;
	localparam logic [5:0] CNT_BYTE2_LAST  = 6'h1a;
	localparam logic [5:0] CNT_CONV_END    = 6'h15;
	localparam logic [5:0] CNT_MAX         = 6'h3f;

	// transfer phases, one-hot
	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_ADDR   = 5'h02,
		ST_WRITE  = 5'h04,
		ST_READ   = 5'h08,
		ST_IGNORE = 5'h10
	} phase_e;

endpackage : touch_cmd_pkg

// ---- hdl/touch_panel_command_port.sv ----
`timescale 1ns/100ps

// How it works
// - address byte is 100100, select-pin level, then read/write flag.
// - flag one means read, flag zero means write.
// - on address match the device pulls sda low in the acknowledge clock.
// - a write carries one msb-first command byte, acknowledged by the device.
// - command bits: start, channel[2:0], ignored, power-down, mode, ignored.
// - every command bit is taken on a rising scl edge.
// - start flag one is accelerate or axis, zero is sleep.
// - mode bit picks 12 or 8 bit result, or the sleep variant.
// - axis and pressure codes select fixed switch and input pairs.
// - accelerate codes use the same switch pairs as the axis and pressure codes.
// - reads reuse the channel and mode of the last write.
// - read data msb first; 12-bit mode pads four zero bits.
// - 12-bit read sends upper eight bits, then four bits and zeros.
// - each read converts afresh; the command stays until replaced.
// - sleep opens all drive lines; pen output floats or drives high.
// - sleep starts at the 16th rising scl; no conversion then.
// - a start-flag-one command wakes the device at the 16th rising scl.
// - sleep repeated keeps sleeping; power-up state is normal mode.
// - power-down zero: only y_minus on, pen detect; one: selected switch pair on, pen low.
// - sample one scl period ending the address byte, then 13 periods.
// - accelerate closes switches at the 18th falling scl of the write.
module touch_panel_command_port
	import touch_cmd_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output      logic        sdaOut,
	output      logic        sdaOe,
	input  wire logic        deviceAddressSelect,
	input  wire logic        penTouch,
	input  wire logic [11:0] adcResult,
	output      logic        xPlusOn,
	output      logic        xMinusOn,
	output      logic        yPlusOn,
	output      logic        yMinusOn,
	output      logic [2:0]  channelSelect,
	output      logic        resolution8,
	output      logic        sampleHold,
	output      logic        convertActive,
	output      logic        penInterruptNOut,
	output      logic        penInterruptNOe
);

	// switch set of a channel code: {x_plus, x_minus, y_plus, y_minus}
	function automatic logic [3:0] switchSet(input logic [2:0] chan);
		case (chan[1:0])
			2'h0:    switchSet = 4'hc;
			2'h1:    switchSet = 4'h3;
			default: switchSet = 4'h6;
		endcase
	endfunction : switchSet

	// pin synchroniser: bit 0 scl, 1 sda, 2 address select, 3 pen touch
	logic [3:0]  sync1_q;
	logic [3:0]  sync2_q;
	logic [3:0]  sync3_q;
	logic [3:0]  filt_q;
	logic [3:0]  filt_d;
	logic        sclRise;
	logic        sclFall;
	logic        startSeen;
	logic        stopSeen;
	logic        sdaBit;
	phase_e      phase_q;
	phase_e      phase_d;
	logic [5:0]  rCnt_q;
	logic [6:0]  shift_q;
	logic [7:0]  addrByte;
	logic        addrOk;
	logic [6:0]  cmdBits;
	logic        cmdStart_q;
	logic [2:0]  chan_q;
	logic        pdSel_q;
	logic        mode_q;
	logic        asleep_q;
	logic        accelOn_q;
	logic        moreWanted_q;
	logic [7:0]  tx_q;
	logic        txEn_q;
	logic [3:0]  lowNibble_q;
	logic        sampleWin_q;
	logic        convWin_q;
	logic [3:0]  sw_d;
	logic        penOut_d;
	logic        penOe_d;
	logic        sdaOe_q;
	logic [3:0]  sw_q;
	logic        penOut_q;
	logic        penOe_q;

	// a change counts once stages two and three agree; reset to idle: no false pen or start
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sync1_q <= 4'h3;
			sync2_q <= 4'h3;
			sync3_q <= 4'h3;
			filt_q  <= 4'h3;
		end else begin
			sync1_q <= {penTouch, deviceAddressSelect, sdaIn, sclIn};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q  <= filt_d;
		end
	end

	// edge and bus condition decode on the filtered levels
	assign filt_d    = (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q));
	assign sclRise   = filt_d[0] & ~filt_q[0];
	assign sclFall   = ~filt_d[0] & filt_q[0];
	assign startSeen = filt_q[0] & filt_d[0] & filt_q[1] & ~filt_d[1];
	assign stopSeen  = filt_q[0] & filt_d[0] & ~filt_q[1] & filt_d[1];
	assign sdaBit    = filt_d[1];

	// address and command bytes assembled from the shifter plus the live bit
	assign addrByte = {shift_q, sdaBit};
	assign addrOk   = (addrByte[7:2] == ADDR_FIXED) &&
		(addrByte[ADDR_SEL_BIT] == filt_q[2]);
	assign cmdBits  = {shift_q[5:0], sdaBit};

	// phase sequencing; a start always wins so a restart is never missed
	always_comb begin
		phase_d = phase_q;
		if (startSeen) begin
			phase_d = ST_ADDR;
		end else if (stopSeen) begin
			phase_d = ST_IDLE;
		end else if (sclRise && phase_q == ST_ADDR && rCnt_q == CNT_ADDR_LAST - 6'h01) begin
			if (!addrOk) begin
				phase_d = ST_IGNORE;
			end else if (addrByte[ADDR_RW_BIT]) begin
				phase_d = ST_READ;
			end else begin
				phase_d = ST_WRITE;
			end
		end
	end

	// rising edge count since start, and the msb-first bit shifter
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			phase_q <= ST_IDLE;
			rCnt_q  <= 6'h00;
			shift_q <= 7'h00;
		end else begin
			phase_q <= phase_d;
			if (startSeen) begin
				rCnt_q <= 6'h00;
			end else if (sclRise && rCnt_q != CNT_MAX) begin
				rCnt_q <= rCnt_q + 6'h01;
			end
			if (sclRise) begin
				shift_q <= {shift_q[5:0], sdaBit};
			end
		end
	end

	// command is applied at the 16th rising edge, when bits 7..1 are in
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cmdStart_q <= START_RST;
			chan_q     <= CHAN_RST;
			pdSel_q    <= PD_RST;
			mode_q     <= MODE_RST;
			asleep_q   <= ASLEEP_RST;
		end else if (sclRise && phase_q == ST_WRITE && rCnt_q == CNT_CMD_APPLY - 6'h01) begin
			cmdStart_q <= cmdBits[CMD_START_BIT - 1];
			chan_q     <= cmdBits[CMD_CHAN_HI - 1:CMD_CHAN_LO - 1];
			pdSel_q    <= cmdBits[CMD_PD_BIT - 1];
			mode_q     <= cmdBits[CMD_MODE_BIT - 1];
			asleep_q   <= ~cmdBits[CMD_START_BIT - 1];
		end
	end

	// accelerate drive is armed at the 18th falling edge, dropped by a new command
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			accelOn_q <= 1'h0;
		end else if (sclRise && phase_q == ST_WRITE && rCnt_q == CNT_CMD_APPLY - 6'h01) begin
			accelOn_q <= 1'h0;
		end else if (sclFall && phase_q == ST_WRITE && rCnt_q == CNT_CMD_ACK) begin
			accelOn_q <= cmdStart_q & ~chan_q[2];
		end
	end

	// sample window scl7 fall to scl8 fall, then conversion up to scl21 fall
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sampleWin_q <= 1'h0;
			convWin_q   <= 1'h0;
		end else if (startSeen || stopSeen) begin
			sampleWin_q <= 1'h0;
			convWin_q   <= 1'h0;
		end else if (sclFall) begin
			sampleWin_q <= (rCnt_q == CNT_SAMPLE_FALL) && !asleep_q;
			if (rCnt_q == CNT_ADDR_LAST) begin
				convWin_q <= phase_q == ST_READ && !asleep_q;
			end else if (rCnt_q == CNT_CONV_END) begin
				convWin_q <= 1'h0;
			end
		end
	end

	// sda drive: acknowledges, then read data msb first; a one releases the line
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			tx_q         <= 8'hff;
			txEn_q       <= 1'h0;
			lowNibble_q  <= 4'h0;
			moreWanted_q <= 1'h0;
			sdaOe_q      <= 1'h0;
		end else if (startSeen || stopSeen || phase_q == ST_IGNORE) begin
			txEn_q  <= 1'h0;
			sdaOe_q <= 1'h0;
		end else begin
			if (sclRise && phase_q == ST_READ && rCnt_q == CNT_BYTE1_ACK - 6'h01) begin
				moreWanted_q <= ~sdaBit & ~mode_q;
			end
			if (sclFall) begin
				if (rCnt_q == CNT_ADDR_LAST && phase_q != ST_ADDR) begin
					sdaOe_q <= 1'h1;
				end else if (rCnt_q == CNT_ADDR_ACK && phase_q == ST_READ) begin
					tx_q        <= adcResult[11:4];
					lowNibble_q <= adcResult[3:0];
					txEn_q      <= 1'h1;
					sdaOe_q     <= ~adcResult[11];
				end else if (rCnt_q == CNT_CMD_LAST && phase_q == ST_WRITE) begin
					sdaOe_q <= 1'h1;
				end else if (rCnt_q == CNT_BYTE1_ACK && phase_q == ST_READ && moreWanted_q) begin
					tx_q    <= {lowNibble_q, 4'h0};
					txEn_q  <= 1'h1;
					sdaOe_q <= ~lowNibble_q[3];
				end else if (txEn_q && rCnt_q != CNT_BYTE1_LAST && rCnt_q != CNT_BYTE2_LAST) begin
					tx_q    <= {tx_q[6:0], 1'h1};
					sdaOe_q <= ~tx_q[6];
				end else begin
					txEn_q  <= 1'h0;
					sdaOe_q <= 1'h0;
				end
			end
		end
	end

	// panel switches: sleep opens all; else drive while armed, converting or held on
	assign sw_d = asleep_q ? 4'h0 :
		(pdSel_q || accelOn_q || sampleWin_q || convWin_q) ? switchSet(chan_q) :
		4'h1;

	// pen output: sleep floats or drives high; detection only when fully idle
	assign penOe_d  = !(asleep_q && mode_q);
	assign penOut_d = asleep_q ? 1'h1 :
		(pdSel_q || accelOn_q || sampleWin_q || convWin_q) ? 1'h0 :
		~filt_q[3];

	// every pin but the constant sdaOut leaves through a flop so no decode glitch reaches the panel
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sw_q     <= 4'h1;
			penOut_q <= 1'h1;
			penOe_q  <= 1'h1;
		end else begin
			sw_q     <= sw_d;
			penOut_q <= penOut_d;
			penOe_q  <= penOe_d;
		end
	end

	assign sdaOut           = 1'h0;
	assign sdaOe            = sdaOe_q;
	assign {xPlusOn, xMinusOn, yPlusOn, yMinusOn} = sw_q;
	assign channelSelect    = chan_q;
	assign resolution8      = mode_q;
	assign sampleHold       = sampleWin_q;
	assign convertActive    = convWin_q;
	assign penInterruptNOut = penOut_q;
	assign penInterruptNOe  = penOe_q;

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence s_addrMatch;
		sclFall && rCnt_q == CNT_ADDR_LAST && (phase_q == ST_READ || phase_q == ST_WRITE);
	endsequence
	sequence s_cmdApply;
		sclRise && phase_q == ST_WRITE && rCnt_q == CNT_CMD_APPLY - 6'h01;
	endsequence
	sequence s_accelArm;
		sclFall && phase_q == ST_WRITE && rCnt_q == CNT_CMD_ACK && cmdStart_q && !chan_q[2];
	endsequence

	property p_ackAddr;
		s_addrMatch |=> sdaOe_q;
	endproperty
	a_ackAddr: assert property (p_ackAddr) else $error("no address acknowledge");

	property p_ignore;
		phase_q == ST_IGNORE |-> !sdaOe_q;
	endproperty
	a_ignore: assert property (p_ignore) else $error("sda driven after mismatch");

	property p_rwFlag;
		sclRise && phase_q == ST_ADDR && rCnt_q == CNT_ADDR_LAST - 6'h01 && addrOk
			|=> (phase_q == ST_READ) == $past(sdaBit);
	endproperty
	a_rwFlag: assert property (p_rwFlag) else $error("read/write flag misread");

	property p_sleepEnter;
		s_cmdApply ##0 !shift_q[5] |=> asleep_q;
	endproperty
	a_sleepEnter: assert property (p_sleepEnter) else $error("sleep not entered");

	property p_sleepLeave;
		s_cmdApply and shift_q[5] |=> !asleep_q ##1 !asleep_q;
	endproperty
	a_sleepLeave: assert property (p_sleepLeave) else $error("sleep not left");

	property p_sleepOpen;
		asleep_q [*2] ##0 $stable(mode_q)
			|-> sw_q == 4'h0 && penOe_q == !mode_q && (mode_q || penOut_q);
	endproperty
	a_sleepOpen: assert property (p_sleepOpen) else $error("panel not open in sleep");

	property p_pdHeld;
		(!asleep_q && pdSel_q) [*2] ##0 $stable(chan_q)
			|-> !penOut_q && sw_q == switchSet(chan_q);
	endproperty
	a_pdHeld: assert property (p_pdHeld) else $error("power-down one not held");

	property p_accel;
		s_accelArm |=> accelOn_q ##1 (sw_q == switchSet(chan_q) || asleep_q);
	endproperty
	a_accel: assert property (p_accel) else $error("accelerate drive late");

	property p_firstBit;
		sclFall && rCnt_q == CNT_ADDR_ACK && phase_q == ST_READ
			|=> sdaOe_q == !$past(adcResult[11]) && tx_q == $past(adcResult[11:4]);
	endproperty
	a_firstBit: assert property (p_firstBit) else $error("first data bit wrong");

	property p_convSleep;
		asleep_q [*2] |-> !convWin_q && !sampleWin_q;
	endproperty
	a_convSleep: assert property (p_convSleep) else $error("conversion while asleep");

endmodule : touch_panel_command_port

// ---- tb/i2c_master_model.sv ----
`timescale 1ns/100ps

// bus master model: drives scl, pulls sda low, the line idles high by pull-up
module i2c_master_model (
	input  wire logic mclk,
	input  wire logic sdaLine,
	output      logic scl,
	output      logic sdaPull
);
	// scl stands high outside frames
	initial begin
		scl = 1'b1;
		sdaPull = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick

	// also serves as repeated start after an ack clock
	task automatic startCond();
		sdaPull <= 1'b0;
		tick(8);
		scl <= 1'b1;
		tick(8);
		sdaPull <= 1'b1;
		tick(8);
		scl <= 1'b0;
		tick(8);
	endtask : startCond

	task automatic stopCond();
		sdaPull <= 1'b1;
		tick(8);
		scl <= 1'b1;
		tick(8);
		sdaPull <= 1'b0;
		tick(24);
	endtask : stopCond

	// sda moves only well inside scl low, so no false start or stop is seen
	task automatic bitXfer(input logic b, output logic r);
		sdaPull <= ~b;
		tick(8);
		scl <= 1'b1;
		tick(8);
		r = sdaLine;
		tick(8);
		scl <= 1'b0;
		tick(8);
	endtask : bitXfer

	// eight bits msb first, then the ninth clock; a one releases the line
	task automatic xferByte(input logic [7:0] d, input logic ackIn,
		output logic [7:0] q, output logic ackOut);
		for (int i = 7; i >= 0; i--) begin
			bitXfer(d[i], q[i]);
		end
		bitXfer(ackIn, ackOut);
	endtask : xferByte
endmodule : i2c_master_model

// ---- tb/touch_panel_command_port_tb_top.sv ----
`timescale 1ns/100ps
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin numErrors++; \
 $display("[ERR] %0t got %h exp %h", $time, a, e); end end

module touch_panel_command_port_tb_top
	import touch_cmd_pkg::*;
;
	typedef struct packed {logic [7:0] cmd; logic [3:0] sw;} row_s;
	logic        mclk = 1'b0;
	logic        nrst;
	logic        penTouch;
	logic [11:0] adc;
	logic        sdaOut, sdaOe, xp, xn, yp, yn, res8, sh, ca, penOut, penOe;
	logic [2:0]  chan;
	logic        scl, sdaPull;
	wire logic   sdaLine;
	int          numErrors = 0;
	int          checkCount = 0;
	logic        addrSel;
	int          caCycles = 0;
	int          shCycles = 0;
	localparam int SCL_CYC = 32;
	// power-down bit set so the selected drive is held; ignored bits toggled
	row_s rows[8] = '{'{8'h84, 4'hc}, '{8'h9e, 4'h3}, '{8'ha5, 4'h6}, '{8'hb6, 4'h6},
		'{8'hc4, 4'hc}, '{8'hdf, 4'h3}, '{8'he4, 4'h6}, '{8'hf6, 4'h6}};

	// open-drain line: low if either party pulls
	assign sdaLine = ~(sdaPull | (sdaOe & ~sdaOut));

	always #2.5 mclk = ~mclk;

	// window lengths in clock cycles; each read compares how far the sample window grew, 12-bit reads the conversion window too
	always @(posedge mclk) begin
		if (ca === 1'b1) begin
			caCycles <= caCycles + 1;
		end
		if (sh === 1'b1) begin
			shCycles <= shCycles + 1;
		end
	end

	touch_panel_command_port DUT (.mclk(mclk), .nrst(nrst), .sclIn(scl), .sdaIn(sdaLine),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .deviceAddressSelect(addrSel), .penTouch(penTouch),
		.adcResult(adc), .xPlusOn(xp), .xMinusOn(xn), .yPlusOn(yp), .yMinusOn(yn),
		.channelSelect(chan), .resolution8(res8), .sampleHold(sh), .convertActive(ca),
		.penInterruptNOut(penOut), .penInterruptNOe(penOe));

	i2c_master_model master (.mclk(mclk), .sdaLine(sdaLine), .scl(scl), .sdaPull(sdaPull));

	task automatic giveVerdict();
		$display("comparisons %0d mismatches %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : giveVerdict

	// write transfer; a refused address must get neither acknowledge
	task automatic wrCmd(input logic [7:0] addr, input logic [7:0] cmd, input logic hit);
		logic [7:0] q;
		logic       a1;
		logic       a2;
		master.startCond();
		master.xferByte(addr, 1'b1, q, a1);
		master.xferByte(cmd, 1'b1, q, a2);
		master.stopCond();
		`CHK(a1, ~hit)
		`CHK(a2, ~hit)
	endtask : wrCmd

	task automatic wr(input logic [7:0] cmd);
		wrCmd({ADDR_FIXED, 1'b1, 1'b0}, cmd, 1'b1);
	endtask : wr

	// read transfer; second byte only in 12-bit mode
	task automatic rd(input logic twelve, input logic [11:0] v);
		logic [7:0] q;
		logic       a;
		int         caBase;
		int         shBase;
		caBase = caCycles;
		shBase = shCycles;
		master.startCond();
		master.xferByte({ADDR_FIXED, 1'b1, 1'b1}, 1'b1, q, a);
		`CHK(a, 1'b0)
		master.xferByte(8'hff, ~twelve, q, a);
		`CHK(q, v[11:4])
		if (twelve) begin
			master.xferByte(8'hff, 1'b1, q, a);
			`CHK(q, {v[3:0], 4'h0})
		end
		master.stopCond();
		`CHK(shCycles - shBase, SCL_CYC)
		if (twelve) begin
			`CHK(caCycles - caBase, 13 * SCL_CYC)
		end
	endtask : rd

	initial begin
		nrst <= 1'b0;
		addrSel <= 1'b1;
		penTouch <= 1'b0;
		adc <= 12'h000;
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		repeat (8) @(posedge mclk);
		// every channel code, drive held, pen forced low
		foreach (rows[i]) begin
			wr(rows[i].cmd);
			`CHK({xp, xn, yp, yn}, rows[i].sw)
			`CHK(chan, rows[i].cmd[6:4])
			`CHK(res8, rows[i].cmd[1])
			`CHK(penOut, 1'b0)
		end
		$display("test command table done");
		// auto power-down: only y_minus closed, pen follows the touch
		wr(8'hc0);
		`CHK({xp, xn, yp, yn, penOut}, 5'h03)
		penTouch <= 1'b1;
		repeat (8) @(posedge mclk);
		`CHK(penOut, 1'b0)
		penTouch <= 1'b0;
		$display("test auto power-down done");
		// accelerate with power-down zero: drive from the 18th fall, pen held low
		wr(8'h90);
		`CHK({xp, xn, yp, yn, penOut}, 5'h06)
		$display("test accelerate done");
		// two 12-bit reads without a new command, then an 8-bit read after one; each result fresh
		adc <= 12'habc;
		rd(1'b1, 12'habc);
		adc <= 12'h5a3;
		rd(1'b1, 12'h5a3);
		wr(8'hc2);
		`CHK(res8, 1'b1)
		adc <= 12'h3c7;
		rd(1'b0, 12'h3c7);
		$display("test reads done");
		// both sleep variants, a repeated sleep, then wake
		wr(8'h72);
		`CHK({xp, xn, yp, yn, penOe}, 5'h00)
		wr(8'h72);
		`CHK({xp, xn, yp, yn, penOe}, 5'h00)
		wr(8'h70);
		`CHK({xp, xn, yp, yn, penOe, penOut}, 6'h03)
		wr(8'hd4);
		`CHK({xp, xn, yp, yn, penOut}, 5'h06)
		$display("test sleep done");
		// wrong fixed bits, then wrong select bit: command must not land
		wrCmd({6'h25, 1'b1, 1'b0}, 8'hc4, 1'b0);
		wrCmd({ADDR_FIXED, 1'b0, 1'b0}, 8'hc4, 1'b0);
		`CHK({xp, xn, yp, yn}, 4'h3)
		// select strap low: the select bit of the address must follow the pin
		addrSel <= 1'b0;
		repeat (8) @(posedge mclk);
		wrCmd({ADDR_FIXED, 1'b0, 1'b0}, 8'hc4, 1'b1);
		wrCmd({ADDR_FIXED, 1'b1, 1'b0}, 8'hc0, 1'b0);
		`CHK({xp, xn, yp, yn}, 4'hc)
		addrSel <= 1'b1;
		$display("test refused address done");
		// second reset in mid-run, looked at while held and two edges after release
		nrst <= 1'b0;
		repeat (12) @(posedge mclk);
		for (int k = 0; k < 2; k++) begin
			`CHK({xp, xn, yp, yn, chan, res8, penOut, penOe, sdaOe, sh, ca},
				{4'h1, CHAN_RST, MODE_RST, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0})
			nrst <= 1'b1;
			repeat (2) @(posedge mclk);
		end
		$display("test reset done");
		giveVerdict();
	end

	// cut a hang at several times the expected run length
	initial begin
		repeat (80000) @(posedge mclk);
		numErrors++;
		giveVerdict();
	end
endmodule : touch_panel_command_port_tb_top
